// *** core/e1ram_defs.svh ***
// Register offsets, field positions and timing counts of the alarm monitor
`ifndef E1RAM_DEFS_SVH
`define E1RAM_DEFS_SVH

// Register indices (byte address is four times the index)
`define E1RAM_IDX_STATE      8'hB9
`define E1RAM_IDX_ENABLE     8'hBA
`define E1RAM_IDX_FLAGS      8'hBB
`define E1RAM_IDX_CRITERIA   8'hBC
`define E1RAM_LINK_BIT       8

// Alarm bit positions, shared by state, enable and flag registers
`define E1RAM_BIT_S16LOSS    5
`define E1RAM_BIT_S16AIS     4
`define E1RAM_BIT_RMULTI     3
`define E1RAM_BIT_ALLONES    2
`define E1RAM_BIT_REMOTE     1
`define E1RAM_BIT_CARRIER    0
`define E1RAM_ALARM_MASK     8'h3F

// Criteria select fields
`define E1RAM_BIT_AISCRIT    1
`define E1RAM_BIT_RAICRIT    0
`define E1RAM_CRIT_MASK      8'h03

// Reset values
`define E1RAM_RST_ENABLE     6'h00
`define E1RAM_RST_CRITERIA   2'h0

// Detection counts
`define E1RAM_S16_RUN        5'd16
`define E1RAM_S16_PERIOD     4'hF
`define E1RAM_S16_FEWZ       3'd4
`define E1RAM_Y_RUN          2'd3
`define E1RAM_A_RUN          3'd4
`define E1RAM_WIN_LAST       9'h1FF
`define E1RAM_WIN_FEWZ       2'd3

// Carrier fail persistence time
`define E1RAM_CLK_HZ         50000000
`define E1RAM_RED_TIME_MS    100
`define E1RAM_RED_CYCLES     (`E1RAM_RED_TIME_MS * (`E1RAM_CLK_HZ / 1000))

`endif

// *** core/e1ram_pkg.sv ***
// Types shared by the receive alarm monitor
package e1ram_pkg;

  // Receive stream and alignment state from the framer, per link
  typedef struct packed {
    logic bitStrobe;    // One received line bit this cycle
    logic bitValue;     // Its value
    logic slot16Bit;    // That bit lies in timeslot 16
    logic slot16End;    // That bit is the last of timeslot 16
    logic aStrobe;      // Bit is the A bit (remote alarm indication)
    logic yStrobe;      // Bit is the Y bit of the CAS multiframe
    logic frameSync;    // Basic frame alignment held
    logic casSync;      // CAS multiframe alignment held
  } e1ram_rx_t;

  typedef logic [5:0] e1ram_alarm_t;
  typedef logic [1:0] e1ram_crit_t;

endpackage : e1ram_pkg

// *** core/e1ram_top.sv ***
// Dual-link E1 receive alarm monitor with Avalon-MM register access
`timescale 1ns/1ns
`include "e1ram_defs.svh"

module e1ram_link #(
  parameter int RED_CYCLES = `E1RAM_RED_CYCLES
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  // Receive stream
  input  wire e1ram_pkg::e1ram_rx_t  rx,
  // Control
  input  wire e1ram_pkg::e1ram_crit_t criteria,
  input  wire e1ram_pkg::e1ram_alarm_t clearMask,
  // Status
  output e1ram_pkg::e1ram_alarm_t alarmState,
  output e1ram_pkg::e1ram_alarm_t changeFlags
);
  import e1ram_pkg::*;

  logic       s16LossReg;
  logic       s16AisReg;
  logic       rMultiReg;
  logic       allOnesReg;
  logic       remoteReg;
  logic       carrierReg;
  logic       octetOneReg;
  logic [4:0] zeroOctetRunReg;
  logic [3:0] frameCountReg;
  logic [2:0] s16ZeroReg;
  logic       s16FewPrevReg;
  logic [1:0] yRunReg;
  logic [2:0] aRunReg;
  logic [8:0] winCountReg;
  logic [1:0] winZeroReg;
  logic       winFewPrevReg;
  logic [22:0] redCountReg;
  e1ram_alarm_t prevStateReg;
  e1ram_alarm_t flagsReg;

  logic       octetZero;
  logic       s16Few;
  logic       winFew;
  logic       winEndFew;
  logic       bitZero;

  assign bitZero   = rx.bitStrobe & ~rx.bitValue;
  assign octetZero = ~octetOneReg & ~(rx.bitStrobe & rx.bitValue);
  assign s16Few    = (s16ZeroReg + {2'b00, bitZero & rx.slot16Bit})
                     < `E1RAM_S16_FEWZ;
  assign winFew    = winZeroReg < `E1RAM_WIN_FEWZ;
  // Window verdict must count a zero in its last bit as well
  assign winEndFew = ({1'b0, winZeroReg} + {2'b00, bitZero})
                     < {1'b0, `E1RAM_WIN_FEWZ};

  // Slot16 octet content and zero-octet run
  always_ff @(posedge clk) begin
    if (!rstn || !rx.frameSync) begin
      octetOneReg     <= 1'b0;
      zeroOctetRunReg <= 5'd0;
      s16LossReg      <= 1'b0;
    end else if (rx.bitStrobe && rx.slot16Bit) begin
      if (rx.slot16End) begin
        octetOneReg <= 1'b0;
        if (octetZero) begin
          if (zeroOctetRunReg != `E1RAM_S16_RUN) begin
            zeroOctetRunReg <= zeroOctetRunReg + 5'd1;
          end
          if (zeroOctetRunReg == `E1RAM_S16_RUN - 5'd1) begin
            s16LossReg <= 1'b1;
          end
        end else begin
          zeroOctetRunReg <= 5'd0;
          s16LossReg      <= 1'b0;
        end
      end else if (rx.bitValue) begin
        octetOneReg <= 1'b1;
      end
    end
  end

  // Slot16 zero count over 16-frame periods
  always_ff @(posedge clk) begin
    if (!rstn || !rx.frameSync) begin
      frameCountReg <= 4'h0;
      s16ZeroReg    <= 3'd0;
      s16FewPrevReg <= 1'b0;
      s16AisReg     <= 1'b0;
    end else if (rx.bitStrobe && rx.slot16Bit) begin
      if (rx.slot16End && frameCountReg == `E1RAM_S16_PERIOD) begin
        frameCountReg <= 4'h0;
        s16ZeroReg    <= 3'd0;
        s16FewPrevReg <= s16Few;
        if (s16Few && s16FewPrevReg) begin
          s16AisReg <= 1'b1;
        end else if (!s16Few) begin
          s16AisReg <= 1'b0;
        end
      end else begin
        if (rx.slot16End) begin
          frameCountReg <= frameCountReg + 4'h1;
        end
        // Saturate: only "fewer than four" matters
        if (!rx.bitValue && s16ZeroReg != `E1RAM_S16_FEWZ) begin
          s16ZeroReg <= s16ZeroReg + 3'd1;
        end
      end
    end
  end

  // Remote multiframe alarm from Y bits
  always_ff @(posedge clk) begin
    if (!rstn || !rx.casSync) begin
      yRunReg   <= 2'd0;
      rMultiReg <= 1'b0;
    end else if (rx.bitStrobe && rx.yStrobe) begin
      if (!rx.bitValue) begin
        yRunReg   <= 2'd0;
        rMultiReg <= 1'b0;
      end else begin
        if (yRunReg != `E1RAM_Y_RUN) begin
          yRunReg <= yRunReg + 2'd1;
        end
        if (yRunReg == `E1RAM_Y_RUN - 2'd1) begin
          rMultiReg <= 1'b1;
        end
      end
    end
  end

  // Remote alarm from A bits
  always_ff @(posedge clk) begin
    if (!rstn || !rx.frameSync) begin
      aRunReg   <= 3'd0;
      remoteReg <= 1'b0;
    end else if (rx.bitStrobe && rx.aStrobe) begin
      if (!rx.bitValue) begin
        aRunReg   <= 3'd0;
        remoteReg <= 1'b0;
      end else begin
        if (aRunReg != `E1RAM_A_RUN) begin
          aRunReg <= aRunReg + 3'd1;
        end
        if (criteria[`E1RAM_BIT_RAICRIT]) begin
          remoteReg <= 1'b1;
        end else if (aRunReg == `E1RAM_A_RUN - 3'd1) begin
          remoteReg <= 1'b1;
        end
      end
    end
  end

  // All-ones detection over fixed 512-bit windows; with criterion bit clear, setting needs frame alignment lost
  always_ff @(posedge clk) begin
    if (!rstn) begin
      winCountReg   <= 9'h000;
      winZeroReg    <= 2'd0;
      winFewPrevReg <= 1'b0;
      allOnesReg    <= 1'b0;
    end else if (rx.bitStrobe) begin
      winCountReg <= winCountReg + 9'h001;
      if (winCountReg == `E1RAM_WIN_LAST) begin
        winZeroReg    <= 2'd0;
        winFewPrevReg <= winEndFew;
        if (!criteria[`E1RAM_BIT_AISCRIT]) begin
          if (winEndFew && !rx.frameSync) begin
            allOnesReg <= 1'b1;
          end else if (!winEndFew) begin
            allOnesReg <= 1'b0;
          end
        end else begin
          if (winEndFew && winFewPrevReg) begin
            allOnesReg <= 1'b1;
          end else if (!winEndFew && !winFewPrevReg) begin
            allOnesReg <= 1'b0;
          end
        end
      end else if (bitZero && winFew) begin
        winZeroReg <= winZeroReg + 2'd1;
      end
    end
  end

  // Carrier fail: frame state must disagree with the alarm for 100 ms
  always_ff @(posedge clk) begin
    if (!rstn) begin
      redCountReg <= 23'd0;
      carrierReg  <= 1'b0;
    end else if (rx.frameSync == carrierReg) begin
      if (redCountReg >= 23'(RED_CYCLES - 1)) begin
        redCountReg <= 23'd0;
        carrierReg  <= ~carrierReg;
      end else begin
        redCountReg <= redCountReg + 23'd1;
      end
    end else begin
      redCountReg <= 23'd0;
    end
  end

  always_comb begin
    alarmState = '0;
    alarmState[`E1RAM_BIT_S16LOSS] = s16LossReg;
    alarmState[`E1RAM_BIT_S16AIS]  = s16AisReg;
    alarmState[`E1RAM_BIT_RMULTI]  = rMultiReg;
    alarmState[`E1RAM_BIT_ALLONES] = allOnesReg;
    alarmState[`E1RAM_BIT_REMOTE]  = remoteReg;
    alarmState[`E1RAM_BIT_CARRIER] = carrierReg;
  end

  // Change flags; a new change beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prevStateReg <= '0;
      flagsReg     <= '0;
    end else begin
      prevStateReg <= alarmState;
      flagsReg     <= (flagsReg & ~clearMask)
                      | (alarmState ^ prevStateReg);
    end
  end

  assign changeFlags = flagsReg;

endmodule : e1ram_link

module e1ram_top #(
  parameter int RED_CYCLES = `E1RAM_RED_CYCLES
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  // Avalon-MM slave, byte address
  input  wire logic [10:0]        address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [31:0]        writedata,
  input  wire logic [3:0]         byteenable,
  output logic      [31:0]        readdata,
  output logic                    waitrequest,
  // Receive streams of the two links
  input  wire e1ram_pkg::e1ram_rx_t rx0,
  input  wire e1ram_pkg::e1ram_rx_t rx1,
  // Interrupt, active low
  output logic                    irqN
);
  import e1ram_pkg::*;

  e1ram_rx_t    rxLink   [2];
  e1ram_alarm_t enableReg [2];
  e1ram_crit_t  critReg  [2];
  e1ram_alarm_t clearMask [2];
  e1ram_alarm_t stateLink [2];
  e1ram_alarm_t flagsLink [2];
  logic [31:0]  readdataReg;
  logic         waitReg;
  logic         irqNReg;
  logic [8:0]   regIndex;
  logic         linkSel;
  logic [7:0]   regOffset;
  logic         wrTake;
  logic [7:0]   rdValue;
  logic         anyIrq;

  assign rxLink[0] = rx0;
  assign rxLink[1] = rx1;
  assign regIndex  = address[10:2];
  assign linkSel   = regIndex[`E1RAM_LINK_BIT];
  assign regOffset = regIndex[7:0];
  // Write lands at the edge that sees waitrequest low
  assign wrTake    = write && !waitReg && byteenable[0];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gLink
      always_comb begin
        clearMask[g] = '0;
        if (wrTake && linkSel == 1'(g)
            && regOffset == `E1RAM_IDX_FLAGS) begin
          clearMask[g] = writedata[5:0];
        end
      end

      always_ff @(posedge clk) begin
        if (!rstn) begin
          enableReg[g] <= `E1RAM_RST_ENABLE;
          critReg[g]   <= `E1RAM_RST_CRITERIA;
        end else if (wrTake && linkSel == 1'(g)) begin
          if (regOffset == `E1RAM_IDX_ENABLE) begin
            enableReg[g] <= writedata[5:0];
          end
          if (regOffset == `E1RAM_IDX_CRITERIA) begin
            critReg[g] <= writedata[1:0];
          end
        end
      end

      e1ram_link #(
        .RED_CYCLES (RED_CYCLES)
      ) uLink (
        .clk         (clk),
        .rstn        (rstn),
        .rx          (rxLink[g]),
        .criteria    (critReg[g]),
        .clearMask   (clearMask[g]),
        .alarmState  (stateLink[g]),
        .changeFlags (flagsLink[g])
      );
    end
  endgenerate

  always_comb begin
    case (regOffset)
      `E1RAM_IDX_STATE:    rdValue = {2'b00, stateLink[linkSel]};
      `E1RAM_IDX_ENABLE:   rdValue = {2'b00, enableReg[linkSel]};
      `E1RAM_IDX_FLAGS:    rdValue = {2'b00, flagsLink[linkSel]};
      `E1RAM_IDX_CRITERIA: rdValue = {6'b000000, critReg[linkSel]};
      default:             rdValue = 8'h00;
    endcase
  end

  // One wait cycle per access; waitrequest idles high
  always_ff @(posedge clk) begin
    if (!rstn) begin
      waitReg     <= 1'b1;
      readdataReg <= 32'h0000_0000;
    end else if ((read || write) && waitReg) begin
      waitReg     <= 1'b0;
      readdataReg <= read ? {24'h000000, rdValue} : 32'h0000_0000;
    end else begin
      waitReg <= 1'b1;
    end
  end

  assign anyIrq = |(flagsLink[0] & enableReg[0])
                | |(flagsLink[1] & enableReg[1]);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irqNReg <= 1'b1;
    end else begin
      irqNReg <= ~anyIrq;
    end
  end

  assign readdata    = readdataReg;
  assign waitrequest = waitReg;
  assign irqN        = irqNReg;

endmodule : e1ram_top

// *** bench/e1ram_line_model.sv ***
// Line-side E1 stream source for one receive link
`timescale 1ns/1ns
module e1ram_line_model (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // Pattern controls
  input  wire logic              allOnes,
  input  wire logic              s16Zero,
  input  wire logic              aVal,
  input  wire logic              yVal,
  input  wire logic              frameSync,
  input  wire logic              casSync,
  // Stream to the monitor
  output e1ram_pkg::e1ram_rx_t   rx
);
  import e1ram_pkg::*;
  logic [11:0] pos_reg;
  logic        inSlot;
  logic        aHit;
  logic        yHit;
  // 256 bits a frame, 16 frames a multiframe
  assign inSlot = pos_reg[7:3] == 5'h10;
  assign aHit   = pos_reg[8] && pos_reg[7:0] == 8'h02;
  assign yHit   = pos_reg[11:8] == 4'h0 && pos_reg[7:0] == 8'h85;
  always_ff @(posedge clk) begin
    if (!rstn) pos_reg <= 12'h000;
    else pos_reg <= pos_reg + 12'h001;
  end
  always_comb begin
    rx.bitStrobe = rstn;
    // Idle bits alternate so a live line shows zeros unless allOnes is set
    rx.bitValue  = yHit ? yVal : aHit ? aVal :
                   (inSlot && s16Zero) ? 1'b0 : allOnes | pos_reg[0];
    rx.slot16Bit = inSlot;
    rx.slot16End = pos_reg[7:0] == 8'h87;
    rx.aStrobe   = aHit;
    rx.yStrobe   = yHit;
    rx.frameSync = frameSync;
    rx.casSync   = casSync;
  end
endmodule : e1ram_line_model

// *** bench/e1ram_top_asserts.sv ***
// Bus timing, readback and interrupt mask checks of the alarm monitor
`timescale 1ns/1ns
module e1ram_top_asserts #(
  parameter int RED_CYCLES = 50
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Register bus
  input wire logic [10:0] address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Interrupt
  input wire logic        irqN
);
  logic [5:0] en0_reg;
  logic [5:0] en1_reg;
  logic [1:0] cr0_reg;
  logic [1:0] cr1_reg;
  logic [7:0] idx;
  logic       wDone;
  logic       rDone;
  assign idx   = address[9:2];
  assign wDone = write && !waitrequest && byteenable[0];
  assign rDone = read && !waitrequest;
  // Shadow copies let readback be judged without seeing inside
  always_ff @(posedge clk) begin
    if (!rstn) begin
      en0_reg <= 6'h00;
      en1_reg <= 6'h00;
      cr0_reg <= 2'h0;
      cr1_reg <= 2'h0;
    end else if (wDone && idx == 8'hBA) begin
      if (address[10]) en1_reg <= writedata[5:0];
      else en0_reg <= writedata[5:0];
    end else if (wDone && idx == 8'hBC) begin
      if (address[10]) cr1_reg <= writedata[1:0];
      else cr0_reg <= writedata[1:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_answer_one_cycle: assert property
    ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered next cycle");
  a_wait_single_low: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_idle_no_answer: assert property
    (!read && !write && waitrequest |=> waitrequest)
    else $error("answer without a request");
  a_reset_values: assert property
    ($rose(rstn) |-> waitrequest && irqN && readdata == 32'h0)
    else $error("outputs not at reset values");
  a_unmapped_zero: assert property
    (rDone && (idx < 8'hB9 || idx > 8'hBC) |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_upper_bits_zero: assert property (rDone |-> readdata[31:6] == 26'h0)
    else $error("unused read bits not zero");
  a_enable_readback: assert property (rDone && idx == 8'hBA |->
    readdata[5:0] == (address[10] ? en1_reg : en0_reg))
    else $error("enable readback wrong");
  a_crit_readback: assert property (rDone && idx == 8'hBC |->
    readdata[1:0] == (address[10] ? cr1_reg : cr0_reg))
    else $error("criteria readback wrong");
  a_irq_masked: assert property
    ((en0_reg == 6'h00 && en1_reg == 6'h00) [*3] |-> irqN)
    else $error("interrupt with all enables off");
endmodule : e1ram_top_asserts

bind e1ram_top e1ram_top_asserts #(.RED_CYCLES(RED_CYCLES)) chk_u (.clk,
  .rstn, .address, .read, .write, .writedata, .byteenable, .readdata,
  .waitrequest, .irqN);

// *** bench/e1ram_top_tb.sv ***
// Self-checking bench for the dual-link receive alarm monitor
`timescale 1ns/1ns
module e1ram_top_tb;
  import e1ram_pkg::*;
  localparam logic [10:0] ST = 11'h2E4, EN = 11'h2E8;
  localparam logic [10:0] FL = 11'h2EC, CR = 11'h2F0, L1 = 11'h400;
  logic        clk = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0;
  logic [10:0] address = 11'h000;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic [3:0]  byteenable = 4'hF;
  logic        waitrequest, irqN;
  logic        allOnes = 1'b0, s16Zero = 1'b0, aVal = 1'b0, yVal = 1'b0;
  logic        frameSync = 1'b1, casSync = 1'b1;
  e1ram_rx_t   rx0, rx1;
  int          errors = 0, cmp_count = 0, cyc = 0;

  e1ram_top #(.RED_CYCLES(50)) dut_u (.clk, .rstn, .address, .read,
    .write, .writedata, .byteenable, .readdata, .waitrequest, .rx0, .rx1,
    .irqN);
  e1ram_line_model line0_u (.clk, .rstn, .allOnes, .s16Zero, .aVal, .yVal,
    .frameSync, .casSync, .rx(rx0));
  e1ram_line_model line1_u (.clk, .rstn, .allOnes(1'b0), .s16Zero(1'b0),
    .aVal(1'b0), .yVal(1'b0), .frameSync(1'b1), .casSync, .rx(rx1));

  always #10 clk = ~clk;

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  always @(posedge clk) begin
    cyc++;
    // Tests need about 46000 cycles
    if (cyc == 80000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic acc(input logic wr, input logic [10:0] a,
                     input logic [7:0] d, input logic [3:0] be);
    @(posedge clk);
    address <= a;
    writedata <= {24'h0, d};
    byteenable <= be;
    read <= !wr;
    write <= wr;
    // Only the bench timeout ends a wait
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : acc

  task automatic rd(input logic [10:0] a, input logic [31:0] exp);
    acc(1'b0, a, 8'h00, 4'hF);
    chk(q, exp);
  endtask : rd

  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++)
      rd(ST + 11'(i % 4 * 4) + (i > 3 ? L1 : 11'h0), 32'h0);
    rd(11'h2F4, 32'h0);
    acc(1'b1, EN, 8'hFF, 4'hF);
    rd(EN, 32'h3F);
    acc(1'b1, CR, 8'h02, 4'h0);
    rd(CR, 32'h0);
    acc(1'b1, CR, 8'hFF, 4'hF);
    rd(CR, 32'h3);
    rd(CR + L1, 32'h0);
    acc(1'b1, ST, 8'hFF, 4'hF);
    rd(ST, 32'h0);
    acc(1'b1, CR, 8'h00, 4'hF);
    acc(1'b1, EN, 8'h20, 4'hF);
    $display("register access done");
    s16Zero <= 1'b1;
    repeat (17 * 256) @(posedge clk);
    rd(ST, 32'h20);
    rd(ST + L1, 32'h0);
    rd(FL, 32'h20);
    chk({31'h0, irqN}, 32'h0);
    acc(1'b1, FL, 8'h00, 4'hF);
    rd(FL, 32'h20);
    acc(1'b1, FL, 8'h20, 4'hF);
    repeat (3) @(posedge clk);
    chk({31'h0, irqN}, 32'h1);
    rd(FL, 32'h0);
    s16Zero <= 1'b0;
    repeat (512) @(posedge clk);
    rd(ST, 32'h0);
    rd(FL, 32'h20);
    acc(1'b1, EN, 8'h00, 4'hF);
    acc(1'b1, FL, 8'h3F, 4'hF);
    $display("slot16 loss done");
    @(posedge clk iff rx0.aStrobe);
    aVal <= 1'b1;
    repeat (3 * 512) @(posedge clk);
    rd(ST, 32'h0);
    repeat (512) @(posedge clk);
    rd(ST, 32'h2);
    chk({31'h0, irqN}, 32'h1);
    aVal <= 1'b0;
    repeat (520) @(posedge clk);
    rd(ST, 32'h0);
    acc(1'b1, CR, 8'h01, 4'hF);
    aVal <= 1'b1;
    repeat (520) @(posedge clk);
    rd(ST, 32'h2);
    aVal <= 1'b0;
    repeat (520) @(posedge clk);
    rd(ST, 32'h0);
    acc(1'b1, CR, 8'h00, 4'hF);
    acc(1'b1, FL, 8'h3F, 4'hF);
    $display("remote alarm done");
    yVal <= 1'b1;
    repeat (3 * 4096 + 64) @(posedge clk);
    rd(ST, 32'h8);
    yVal <= 1'b0;
    repeat (4100) @(posedge clk);
    rd(ST, 32'h0);
    rd(FL, 32'h8);
    acc(1'b1, FL, 8'h3F, 4'hF);
    $display("multiframe alarm done");
    allOnes <= 1'b1;
    frameSync <= 1'b0;
    repeat (1100) @(posedge clk);
    rd(ST, 32'h5);
    frameSync <= 1'b1;
    allOnes <= 1'b0;
    repeat (1100) @(posedge clk);
    rd(ST, 32'h0);
    rd(FL, 32'h5);
    acc(1'b1, FL, 8'h3F, 4'hF);
    acc(1'b1, CR, 8'h02, 4'hF);
    allOnes <= 1'b1;
    yVal <= 1'b1;
    repeat (1600) @(posedge clk);
    rd(ST, 32'h4);
    // Slot16 periods span 4096 bits; wait out two full ones
    repeat (11000) @(posedge clk);
    rd(ST, 32'h1C);
    casSync <= 1'b0;
    repeat (2) @(posedge clk);
    rd(ST, 32'h14);
    casSync <= 1'b1;
    yVal <= 1'b0;
    allOnes <= 1'b0;
    repeat (4400) @(posedge clk);
    rd(ST, 32'h0);
    rd(FL, 32'h1C);
    $display("all-ones alarm done");
    wrap_up();
  end
endmodule : e1ram_top_tb
